// file: bench/host_model.sv
// Purpose: Host side driving strobe, data, enables and clear
// Assumes: Strobe period 125 ns, unrelated in phase to clk_sys
// Notes:   Strobe stands high between frames
`timescale 1ns/10ps
module host_model (
   output logic strobe,
   output logic serial_in,
   output logic input_latch_enable_n,
   output logic converter_latch_enable_n,
   output logic clear_n
);
   // ==========================================================
   // Idle levels
   initial
   begin
      strobe = 1'b1;
      serial_in = 1'b0;
      input_latch_enable_n = 1'b1;
      converter_latch_enable_n = 1'b1;
      clear_n = 1'b1;
   end

   // One strobe of 125 ns; setup 62.5 ns, hold 20 ns
   task pulse(input logic in_n, input logic cv_n, input logic d);
      input_latch_enable_n = in_n;
      converter_latch_enable_n = cv_n;
      serial_in = d;
      strobe = 1'b0;
      #62.5 strobe = 1'b1;
      #20 serial_in = ~d;         // Released line shows inverse
      input_latch_enable_n = 1'b1;
      converter_latch_enable_n = 1'b1;
      #42.5;
   endtask : pulse

   // Whole word, MSB first, 16 strobes
   task send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         pulse(1'b0, 1'b1, w[i]);
   endtask : send_word

   // Clear pulse of at least 200 ns
   task clear_pulse;
      clear_n = 1'b0;
      #200 clear_n = 1'b1;
      #100;
   endtask : clear_pulse
endmodule : host_model

// file: bench/serial_dac_latches_tb.sv
// Purpose: Self-checking bench for the serial converter latches
// Assumes: Host model drives all pins except clock, reset and the serial_in of DUT_NEXT, fed from the chain out of DUT
// Notes:   Each scenario settles well past the sampling latency
`timescale 1ns/10ps
module serial_dac_latches_tb;
   logic        clk_sys;
   logic        reset_n;
   logic        strobe;
   logic        serial_in;
   logic        ien_n;
   logic        cen_n;
   logic        clear_n;
   logic [15:0] converter_code;
   logic [15:0] input_word;
   logic        serial_chain_out;
   logic [15:0] next_code;
   logic [15:0] next_word;
   int          n_mismatch;
   int          checked;

   host_model HOST (.strobe(strobe), .serial_in(serial_in),
      .input_latch_enable_n(ien_n), .converter_latch_enable_n(cen_n),
      .clear_n(clear_n));
   serial_dac_latches DUT (.clk_sys(clk_sys), .reset_n(reset_n),
      .strobe(strobe), .serial_in(serial_in),
      .input_latch_enable_n(ien_n), .converter_latch_enable_n(cen_n),
      .clear_n(clear_n), .converter_code(converter_code),
      .input_word(input_word), .serial_chain_out(serial_chain_out));
   // Second converter fed from the chain output of the first
   serial_dac_latches DUT_NEXT (.clk_sys(clk_sys), .reset_n(reset_n),
      .strobe(strobe), .serial_in(serial_chain_out),
      .input_latch_enable_n(ien_n), .converter_latch_enable_n(cen_n),
      .clear_n(clear_n), .converter_code(next_code),
      .input_word(next_word), .serial_chain_out());

   // ==========================================================
   // Clock of 4 ns
   always #2 clk_sys = ~clk_sys;

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task close_out;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   // ==========================================================
   // Scenarios
   task t_load;
      HOST.send_word(16'ha53c);
      chk(input_word, 16'ha53c);
      chk({15'h0000, serial_chain_out}, 16'h0001);
      chk(converter_code, serial_dac_pkg::ZERO_CODE);
      chk(next_word, serial_dac_pkg::ZERO_CODE);
   endtask : t_load

   task t_update;
      HOST.pulse(1'b1, 1'b0, 1'b1);
      chk(converter_code, 16'ha53c);
      chk(input_word, 16'ha53c);
      HOST.pulse(1'b1, 1'b1, 1'b0);
      chk(converter_code, 16'ha53c);
      chk(input_word, 16'ha53c);
   endtask : t_update

   task t_cascade;
      for (int i = 15; i >= 0; i--)
      begin
         chk(next_word, 16'ha53c >> (i + 1));
         chk(16'(serial_chain_out), 16'h0001 & (16'ha53c >> i));
         HOST.pulse(1'b0, 1'b1, 1'b1);
      end
      chk(input_word, serial_dac_pkg::FULL_CODE);
      chk(next_word, 16'ha53c);
      chk(converter_code, 16'ha53c);
      HOST.pulse(1'b1, 1'b0, 1'b0);
      chk(converter_code, serial_dac_pkg::FULL_CODE);
      chk(next_code, 16'ha53c);
   endtask : t_cascade

   task t_both;
      HOST.pulse(1'b0, 1'b0, 1'b0);
      chk(converter_code, serial_dac_pkg::FULL_CODE);
      chk(input_word, 16'hfffe);
      chk(next_word, 16'h4a79);
      HOST.pulse(1'b0, 1'b0, 1'b0);
      chk(converter_code, 16'hfffe);
      chk(input_word, 16'hfffc);
      chk(next_code, 16'h4a79);
      HOST.clear_pulse();
      chk(converter_code, serial_dac_pkg::ZERO_CODE);
      chk(input_word, serial_dac_pkg::ZERO_CODE);
      chk(next_code, serial_dac_pkg::ZERO_CODE);
   endtask : t_both

   // ==========================================================
   // Main sequence
   initial
   begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      n_mismatch = 0;
      checked = 0;
      repeat (10) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      repeat (10) @(posedge clk_sys);
      t_load();
      t_update();
      t_cascade();
      t_both();
      close_out();
   end

   // Watchdog
   initial
   begin
      #30000;
      n_mismatch++;
      close_out();
   end
endmodule : serial_dac_latches_tb

// file: rtl/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input asynchronous to clk_sys
// Notes:   Stage one feeds only stage two
`timescale 1ns/10ps
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic pin,
   output logic      level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   // ==========================================================
   // Chain and filter
   always_comb
   begin
      state_next     = state_reg;
      state_next.s1  = pin;
      state_next.s2  = state_reg.s1;
      state_next.s3  = state_reg.s2;
      if (state_reg.s2 == state_reg.s3)
      begin
         state_next.lvl = state_reg.s3;
      end
   end

   // Registers
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= {INIT, INIT, INIT, INIT};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign level = state_reg.lvl;

endmodule : pin_sync

// file: rtl/serial_dac_latches.sv
// Purpose: Serial input latch and converter latch of a 16-bit converter
// Assumes: Host pins sampled by clk_sys; strobe period well above 12 ns
// Notes:   Latches act on the low-to-high return of the strobe
//
// Overview of operation
// - Input enable low: strobe shifts bit in
// - Converter enable low: strobe copies input word
// - No enables: strobe changes nothing
// - Clear low zeroes both latches at once
// - Input latch MSB drives serial chain out
// - MSB first, straight binary codes
// - Enables low open latch, high holds
// - Full word held before second latch
`timescale 1ns/10ps
module serial_dac_latches (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        strobe,
   input  wire logic        serial_in,
   input  wire logic        input_latch_enable_n,
   input  wire logic        converter_latch_enable_n,
   input  wire logic        clear_n,
   output logic [15:0]      converter_code,
   output logic [15:0]      input_word,
   output logic             serial_chain_out
);

   typedef struct packed {
      serial_dac_pkg::strobe_state_t phase;
      logic [15:0]                   shift;
      logic [15:0]                   code;
      logic                          chain;
      logic                          strobe_done;
   } core_state_t;

   core_state_t         state_reg;
   core_state_t         state_next;
   serial_dac_pkg::pins_t pins;

   // ==========================================================
   // Pin synchronisers
   pin_sync #(.INIT(1'b1)) u_sync_strobe (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pin     (strobe),
      .level   (pins.strobe)
   );
   pin_sync #(.INIT(1'b0)) u_sync_data (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pin     (serial_in),
      .level   (pins.data)
   );
   pin_sync #(.INIT(1'b1)) u_sync_in_en (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pin     (input_latch_enable_n),
      .level   (pins.in_en_n)
   );
   pin_sync #(.INIT(1'b1)) u_sync_conv_en (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pin     (converter_latch_enable_n),
      .level   (pins.conv_en_n)
   );
   pin_sync #(.INIT(1'b0)) u_sync_clear (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pin     (clear_n),
      .level   (pins.clear_n)
   );

   // ==========================================================
   // Strobe tracking and latch updates
   always_comb
   begin
      state_next             = state_reg;
      state_next.strobe_done = 1'b0;
      case (state_reg.phase)
         serial_dac_pkg::STROBE_HIGH:
         begin
            if (!pins.strobe)
            begin
               state_next.phase = serial_dac_pkg::STROBE_LOW;
            end
         end
         serial_dac_pkg::STROBE_LOW:
         begin
            if (pins.strobe)
            begin
               state_next.phase       = serial_dac_pkg::STROBE_HIGH;
               state_next.strobe_done = 1'b1;
               // Enables sampled at the completing edge
               if (!pins.conv_en_n)
               begin
                  state_next.code = state_reg.shift;
               end
               if (!pins.in_en_n)
               begin
                  // MSB first into bit 0, oldest bit at the top
                  state_next.shift = {state_reg.shift[14:0], pins.data};
               end
            end
         end
         default:
         begin
            state_next.phase = serial_dac_pkg::STROBE_HIGH;
         end
      endcase
      // Clear overrides strobe and enables
      if (!pins.clear_n)
      begin
         state_next.shift = serial_dac_pkg::ZERO_CODE;
         state_next.code  = serial_dac_pkg::ZERO_CODE;
      end
      state_next.chain = state_next.shift[serial_dac_pkg::MSB_POS];
   end

   // Registers
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= '{serial_dac_pkg::STROBE_HIGH, 16'h0000, 16'h0000,
                        1'b0, 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs come straight from the state register
   assign converter_code   = state_reg.code;
   assign input_word       = state_reg.shift;
   assign serial_chain_out = state_reg.chain;

   // ==========================================================
   // Checks
   // A strobe_done cycle shows the effect of the pins one cycle
   // earlier, so enables, data and clear are all taken through $past.

   shift_in_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done && !$past(pins.in_en_n) && $past(pins.clear_n)
      |-> state_reg.shift[0] == $past(pins.data))
      else $error("bit not shifted in");

   shift_move_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done && !$past(pins.in_en_n) && $past(pins.clear_n)
      |-> state_reg.shift[15:1] == $past(state_reg.shift[14:0]))
      else $error("older bits not moved towards msb");

   load_code_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done && !$past(pins.conv_en_n) && $past(pins.clear_n)
      |-> state_reg.code == $past(state_reg.shift))
      else $error("word not transferred");

   hold_idle_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      !state_reg.strobe_done && $past(pins.clear_n)
      |-> $stable(state_reg.code) && $stable(state_reg.shift))
      else $error("latch changed without strobe");

   no_enable_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done && $past(pins.in_en_n) && $past(pins.conv_en_n)
      && $past(pins.clear_n)
      |-> $stable(state_reg.shift) && $stable(state_reg.code))
      else $error("latch changed with enables high");

   code_hold_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done && $past(pins.conv_en_n) && $past(pins.clear_n)
      |-> $stable(state_reg.code))
      else $error("converter latch moved while closed");

   word_hold_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done && $past(pins.in_en_n) && $past(pins.clear_n)
      |-> $stable(state_reg.shift))
      else $error("input latch moved while closed");

   clear_zero_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      !pins.clear_n
      |=> state_reg.code == 16'h0000 && state_reg.shift == 16'h0000)
      else $error("clear did not zero latches");

   chain_msb_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      1'b1
      |-> serial_chain_out == input_word[15])
      else $error("chain out not latch msb");

   edge_only_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done
      |-> $past(state_reg.phase) == serial_dac_pkg::STROBE_LOW
      && $past(pins.strobe))
      else $error("strobe done without rising edge");

   pulse_once_a: assert property (@(posedge clk_sys)
      disable iff (!reset_n)
      state_reg.strobe_done
      |=> !state_reg.strobe_done)
      else $error("strobe done held");

   // ==========================================================
   // Scenario coverage
   shift_cover: cover property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg.strobe_done && !$past(pins.in_en_n));
   load_cover: cover property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg.strobe_done && !$past(pins.conv_en_n));
   both_cover: cover property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg.strobe_done && !$past(pins.in_en_n)
      && !$past(pins.conv_en_n));
   idle_cover: cover property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg.strobe_done && $past(pins.in_en_n)
      && $past(pins.conv_en_n));
   clear_cover: cover property (@(posedge clk_sys) disable iff (!reset_n)
      !pins.clear_n && state_reg.code != 16'h0000);

endmodule : serial_dac_latches

// file: rtl/serial_dac_pkg.sv
// Purpose: Shared constants and types for the serial converter latches
// Assumes: Sampling clock of 250 MHz, strobe clock from the host
// Notes:   No other file uses the timing figures below
package serial_dac_pkg;

   // ==========================================================
   // Word layout
   localparam int          WORD_BITS  = 16;
   localparam int          MSB_POS    = 15;
   localparam logic [15:0] ZERO_CODE  = 16'h0000;
   localparam logic [15:0] FULL_CODE  = 16'hffff;

   // ==========================================================
   // Sampling
   localparam int          SYNC_STAGES = 3;
   localparam int          CLK_PERIOD_PS = 4000;

   // ==========================================================
   // Types
   typedef struct packed {
      logic strobe;
      logic data;
      logic in_en_n;
      logic conv_en_n;
      logic clear_n;
   } pins_t;

   typedef enum logic [1:0] {
      STROBE_HIGH = 2'b00,
      STROBE_LOW  = 2'b01
   } strobe_state_t;

endpackage : serial_dac_pkg
